// ===== ncs_pkg.sv
package ncs_pkg;

   // **********
   // sizes
   // **********
   localparam int NUM_AXES = 4;                 // control axes checked
   localparam int ADDR_W   = 8;                 // apb byte address width
   localparam int DATA_W   = 32;                // apb data width

   // **********
   // register offsets (byte addresses)
   // **********
   localparam logic [7:0] OFS_CTRL = 8'h00;     // mode and cycle control
   localparam logic [7:0] OFS_CMD  = 8'h04;     // launch strobe, write only
   localparam logic [7:0] OFS_STAT = 8'h08;     // flag status, read only
   localparam logic [7:0] OFS_AXIS = 8'h0c;     // axis status, read only

   // **********
   // field positions and reset values
   // **********
   localparam int CTRL_MODE_LSB = 0;            // mode request, 3 bits
   localparam int CTRL_MODE_W   = 3;
   localparam int CTRL_HOLD_BIT = 3;            // feed hold, low = hold
   localparam int CTRL_RRW_BIT  = 4;            // reset and rewind
   localparam int CTRL_SBLK_BIT = 5;            // single block
   localparam int CTRL_W        = 6;
   localparam logic [5:0] CTRL_RESET = 6'h08;   // hold released, no mode
   localparam int CMD_LAUNCH_BIT = 0;           // cycle launch strobe
   localparam int STAT_W = 11;                  // flags packed from bit 0
   localparam int AXIS_BUSY_LSB = 0;            // accel/decel pending
   localparam int AXIS_PLC_LSB  = 4;            // sequence-program axes
   localparam int AXIS_SVOF_LSB = 8;            // servo off inputs
   localparam int AXIS_POS_LSB  = 12;           // position control enables
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   // **********
   // types
   // **********
   typedef enum logic [2:0] {
      MODE_NONE, MODE_HOME, MODE_ASET, MODE_MEM,
      MODE_TAPE, MODE_MDI, MODE_MANUAL
   } ncs_mode_e;                                // operating modes

   typedef enum logic [1:0] {
      CYC_RESET, CYC_START, CYC_STOP, CYC_PAUSE
   } ncs_cyc_e;                                 // automatic cycle states

endpackage : ncs_pkg

// ===== ncs_mode_sel.sv
`timescale 1ns/100ps
module ncs_mode_sel
   import ncs_pkg::*;
(
   input  wire logic                   clk_sys,
   input  wire logic                   rst_n,
   input  wire logic [CTRL_MODE_W-1:0] mode_req,
   input  wire logic                   all_axes_no_lag,
   output logic                        homing_mode_flag,
   output logic                        auto_initial_setup_flag,
   output logic                        stored_program_flag,
   output logic                        reel_input_flag,
   output logic                        keyed_entry_flag,
   output logic                        auto_mode
);

   // **********
   // request decode
   // **********
   // unused request codes fall back to no mode
   function automatic ncs_mode_e to_mode(logic [CTRL_MODE_W-1:0] raw);
      ncs_mode_e m;
      m = MODE_NONE;
      case (raw)
         3'h1:    m = MODE_HOME;
         3'h2:    m = MODE_ASET;
         3'h3:    m = MODE_MEM;
         3'h4:    m = MODE_TAPE;
         3'h5:    m = MODE_MDI;
         3'h6:    m = MODE_MANUAL;
         default: m = MODE_NONE;
      endcase
      return m;
   endfunction : to_mode

   ncs_mode_e cur_mode;                         // mode now in force
   ncs_mode_e next_mode;                        // mode after this edge

   // switch only once no axis outside sequence-program control has a smoothing delay left
   always_comb
   begin
      next_mode = cur_mode;
      if (all_axes_no_lag && to_mode(mode_req) != cur_mode)
      begin
         next_mode = to_mode(mode_req);
      end
   end

   // **********
   // mode register and one-hot indicators
   // **********
   // old indicator drops on the same edge the new one rises
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cur_mode                <= MODE_NONE;
         homing_mode_flag        <= 1'b0;
         auto_initial_setup_flag <= 1'b0;
         stored_program_flag     <= 1'b0;
         reel_input_flag         <= 1'b0;
         keyed_entry_flag        <= 1'b0;
         auto_mode               <= 1'b0;
      end
      else
      begin
         cur_mode                <= next_mode;
         homing_mode_flag        <= (next_mode == MODE_HOME);
         auto_initial_setup_flag <= (next_mode == MODE_ASET);
         stored_program_flag     <= (next_mode == MODE_MEM);
         reel_input_flag         <= (next_mode == MODE_TAPE);
         keyed_entry_flag        <= (next_mode == MODE_MDI);
         auto_mode <= (next_mode == MODE_MEM) ||
                      (next_mode == MODE_TAPE) ||
                      (next_mode == MODE_MDI);
      end
   end

endmodule : ncs_mode_sel

// ===== ncs_cycle_fsm.sv
`timescale 1ns/100ps
module ncs_cycle_fsm
   import ncs_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic auto_mode,
   input  wire logic reset_cond,
   input  wire logic cycle_launch_cmd,
   input  wire logic feed_hold_cmd_n,
   input  wire logic single_block,
   input  wire logic blk_end,
   output logic      cycle_running_flag,
   output logic      cycle_executing_flag,
   output logic      cycle_held_flag
);

   ncs_cyc_e state;                             // present cycle state
   ncs_cyc_e next_state;                        // state after this edge

   // **********
   // next state
   // **********
   always_comb
   begin
      next_state = state;
      if (reset_cond || !auto_mode)
      begin
         next_state = CYC_RESET;
      end
      else
      begin
         case (state)
            CYC_RESET, CYC_STOP, CYC_PAUSE:
               // launch is void while feed hold is on
               if (cycle_launch_cmd && feed_hold_cmd_n)
               begin
                  next_state = CYC_START;
               end
            CYC_START:
               if (!feed_hold_cmd_n)
               begin
                  next_state = CYC_PAUSE;
               end
               else if (blk_end && single_block)
               begin
                  next_state = CYC_STOP;
               end
            default:
               next_state = CYC_RESET;
         endcase
      end
   end

   // **********
   // state and flag registers
   // **********
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state                <= CYC_RESET;
         cycle_running_flag   <= 1'b0;
         cycle_executing_flag <= 1'b0;
         cycle_held_flag      <= 1'b0;
      end
      else
      begin
         state                <= next_state;
         cycle_running_flag   <= (next_state != CYC_RESET);
         cycle_executing_flag <= (next_state == CYC_START);
         cycle_held_flag      <= (next_state == CYC_PAUSE);
      end
   end

endmodule : ncs_cycle_fsm

// ===== ncs_status.sv
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
// How it works
// - homing indicator rises after axes show no lag
// - initial-setup indicator waits for no-lag confirmation
// - stored-program indicator waits for no-lag confirmation
// - tape indicator rises when no-lag becomes true
// - keyed-entry indicator rises when no-lag becomes true
// - controller ready set when no clearing condition
// - controller ready cleared by power loss, faults
// - controller ready cleared by unresettable servo alarm
// - servo ready after diagnosis; gates position control
// - servo ready again on alarm reset, stop release
// - servo ready cleared by alarm, stop, power, fault
// - servo off input never clears servo ready
// - launch in automatic mode sets running until reset
// - rewind, emergency stop, alarm clear cycle flags
// - outside automatic operation all cycle flags zero
// - block stop: running only
// - feed hold mid-block: running and held
// - executing: running and executing only
// - no-lag excludes sequence-program axes
module ncs_status
   import ncs_pkg::*;
(
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   // apb slave
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [DATA_W-1:0]   pwdata,
   input  wire logic [3:0]          pstrb,
   output logic      [DATA_W-1:0]   prdata,
   output logic                     pready,
   output logic                     pslverr,
   // machine side inputs
   input  wire logic                power_good,
   input  wire logic                cpu_fault,
   input  wire logic                servo_diag_ok,
   input  wire logic                servo_alarm,
   input  wire logic                alarm_resettable,
   input  wire logic                estop_in,
   input  wire logic [NUM_AXES-1:0] axis_accel_busy,
   input  wire logic [NUM_AXES-1:0] plc_axis,
   input  wire logic [NUM_AXES-1:0] servo_off_cmd_n,
   input  wire logic                blk_end,
   // status flags
   output logic                     homing_mode_flag,
   output logic                     auto_initial_setup_flag,
   output logic                     stored_program_flag,
   output logic                     reel_input_flag,
   output logic                     keyed_entry_flag,
   output logic                     controller_ready_flag,
   output logic                     servo_ready_flag,
   output logic                     cycle_running_flag,
   output logic                     cycle_executing_flag,
   output logic                     cycle_held_flag,
   output logic                     all_axes_no_lag,
   output logic      [NUM_AXES-1:0] pos_ctrl_en
);

   // **********
   // helpers
   // **********
   // falling edge of a level against its last sample
   function automatic logic fell(logic prev, logic now);
      return prev && !now;
   endfunction : fell

   // **********
   // apb decode
   // **********
   logic              setup_ph;                 // first cycle of transfer
   logic              access_ph;                // completing cycle
   logic              wr_ctrl;                  // write to control reg
   logic              wr_cmd;                   // write to command reg
   logic              addr_hit;                 // offset is mapped
   logic [CTRL_W-1:0] ctrl;                     // control register
   logic              launch_pulse;             // one-cycle launch
   logic [STAT_W-1:0] stat_vec;                 // packed flag view
   logic [31:0]       next_rdata;               // read mux result

   // zero wait states: every access completes in one cycle
   assign pready    = 1'b1;
   assign setup_ph  = psel && !penable;
   assign access_ph = psel && penable;
   assign addr_hit  = (paddr == OFS_CTRL) || (paddr == OFS_CMD) ||
                      (paddr == OFS_STAT) || (paddr == OFS_AXIS);
   // only byte lane 0 carries control bits
   assign wr_ctrl   = access_ph && pwrite && pstrb[0] &&
                      (paddr == OFS_CTRL);
   assign wr_cmd    = access_ph && pwrite && pstrb[0] &&
                      (paddr == OFS_CMD);

   // **********
   // control register
   // **********
   // mode request, feed hold, rewind and single block levels
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl <= CTRL_RESET;
      end
      else if (wr_ctrl)
      begin
         ctrl <= pwdata[CTRL_W-1:0];
      end
   end

   // **********
   // launch strobe
   // **********
   // a write of one makes a single launch pulse, no storage
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         launch_pulse <= 1'b0;
      end
      else
      begin
         launch_pulse <= wr_cmd && pwdata[CMD_LAUNCH_BIT];
      end
   end

   // **********
   // read path
   // **********
   assign stat_vec = {all_axes_no_lag,
                      cycle_held_flag,
                      cycle_executing_flag,
                      cycle_running_flag,
                      servo_ready_flag,
                      controller_ready_flag,
                      keyed_entry_flag,
                      reel_input_flag,
                      stored_program_flag,
                      auto_initial_setup_flag,
                      homing_mode_flag};

   // unused upper bits read as zero
   always_comb
   begin
      next_rdata = RD_ZERO;
      case (paddr)
         OFS_CTRL:
            next_rdata[CTRL_W-1:0] = ctrl;
         OFS_STAT:
            next_rdata[STAT_W-1:0] = stat_vec;
         OFS_AXIS:
         begin
            next_rdata[AXIS_BUSY_LSB +: NUM_AXES] = axis_accel_busy;
            next_rdata[AXIS_PLC_LSB  +: NUM_AXES] = plc_axis;
            next_rdata[AXIS_SVOF_LSB +: NUM_AXES] = servo_off_cmd_n;
            next_rdata[AXIS_POS_LSB  +: NUM_AXES] = pos_ctrl_en;
         end
         default:
            next_rdata = RD_ZERO;               // command reg reads zero
      endcase
   end

   // data sampled in setup so it stands through the access cycle
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata <= RD_ZERO;
      end
      else if (setup_ph)
      begin
         prdata <= pwrite ? RD_ZERO : next_rdata;
      end
   end

   // unmapped offsets answer with an error, nothing changes
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pslverr <= 1'b0;
      end
      else if (setup_ph)
      begin
         pslverr <= !addr_hit;
      end
   end

   // **********
   // all axes no lag
   // **********
   // axes under sequence-program control never hold this off
   assign all_axes_no_lag = &(~axis_accel_busy | plc_axis);

   // **********
   // controller ready
   // **********
   logic fatal_alarm;                           // alarm needing power cycle

   // sticky until power drops; alarm reset alone cannot clear it
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fatal_alarm <= 1'b0;
      end
      else if (!power_good)
      begin
         fatal_alarm <= 1'b0;
      end
      else if (servo_alarm && !alarm_resettable)
      begin
         fatal_alarm <= 1'b1;
      end
   end

   // level form: ready whenever no off-condition stands
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         controller_ready_flag <= 1'b0;
      end
      else
      begin
         controller_ready_flag <= power_good && !cpu_fault &&
                                  !fatal_alarm &&
                                  !(servo_alarm && !alarm_resettable);
      end
   end

   // **********
   // servo ready
   // **********
   logic diag_done;                             // power-up diagnosis passed
   logic alarm_prev;                            // alarm last cycle
   logic estop_prev;                            // stop input last cycle
   logic alarm_res;                             // alarm seen as resettable
   logic sv_clear;                              // any off-condition
   logic sv_set;                                // any on-event

   // diagnosis result is kept until power is lost
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         diag_done <= 1'b0;
      end
      else if (!power_good)
      begin
         diag_done <= 1'b0;
      end
      else if (servo_diag_ok)
      begin
         diag_done <= 1'b1;
      end
   end

   // edge history and alarm class while it is active
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         alarm_prev <= 1'b0;
         estop_prev <= 1'b0;
         alarm_res  <= 1'b0;
      end
      else
      begin
         alarm_prev <= servo_alarm;
         estop_prev <= estop_in;
         if (servo_alarm)
         begin
            alarm_res <= alarm_resettable;
         end
      end
   end

   // servo off inputs are deliberately absent from this term
   assign sv_clear = servo_alarm || estop_in ||
                     !power_good || cpu_fault;
   // diagnosis pass, resettable alarm gone, or stop released
   assign sv_set   = (servo_diag_ok && !diag_done) ||
                     (fell(alarm_prev, servo_alarm) && alarm_res) ||
                     fell(estop_prev, estop_in);

   // clear wins: a stop or alarm in the same cycle keeps it low
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         servo_ready_flag <= 1'b0;
      end
      else if (sv_clear)
      begin
         servo_ready_flag <= 1'b0;
      end
      else if (sv_set && (diag_done || servo_diag_ok) && !fatal_alarm)
      begin
         servo_ready_flag <= 1'b1;
      end
   end

   // position loop only runs while servo ready holds
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pos_ctrl_en <= '0;
      end
      else
      begin
         pos_ctrl_en <= {NUM_AXES{servo_ready_flag}} &
                        servo_off_cmd_n;
      end
   end

   // **********
   // mode selection
   // **********
   logic auto_mode;                             // memory, tape or mdi

   ncs_mode_sel u_mode_sel
   (
      .clk_sys                 (clk_sys),
      .rst_n                   (rst_n),
      .mode_req                (ctrl[CTRL_MODE_LSB +: CTRL_MODE_W]),
      .all_axes_no_lag         (all_axes_no_lag),
      .homing_mode_flag        (homing_mode_flag),
      .auto_initial_setup_flag (auto_initial_setup_flag),
      .stored_program_flag     (stored_program_flag),
      .reel_input_flag         (reel_input_flag),
      .keyed_entry_flag        (keyed_entry_flag),
      .auto_mode               (auto_mode)
   );

   // **********
   // automatic cycle
   // **********
   logic reset_cond;                            // forces reset state

   assign reset_cond = ctrl[CTRL_RRW_BIT] || estop_in ||
                       servo_alarm;

   ncs_cycle_fsm u_cycle_fsm
   (
      .clk_sys              (clk_sys),
      .rst_n                (rst_n),
      .auto_mode            (auto_mode),
      .reset_cond           (reset_cond),
      .cycle_launch_cmd     (launch_pulse),
      .feed_hold_cmd_n      (ctrl[CTRL_HOLD_BIT]),
      .single_block         (ctrl[CTRL_SBLK_BIT]),
      .blk_end              (blk_end),
      .cycle_running_flag   (cycle_running_flag),
      .cycle_executing_flag (cycle_executing_flag),
      .cycle_held_flag      (cycle_held_flag)
   );

endmodule : ncs_status

// ===== ncs_status_chk_sva.sv
`timescale 1ns/100ps
module ncs_status_chk
   import ncs_pkg::*;
(
   input wire logic                clk_sys,
   input wire logic                rst_n,
   input wire logic                power_good,
   input wire logic                cpu_fault,
   input wire logic                servo_alarm,
   input wire logic                alarm_resettable,
   input wire logic                estop_in,
   input wire logic [NUM_AXES-1:0] axis_accel_busy,
   input wire logic [NUM_AXES-1:0] plc_axis,
   input wire logic                homing_mode_flag,
   input wire logic                auto_initial_setup_flag,
   input wire logic                stored_program_flag,
   input wire logic                reel_input_flag,
   input wire logic                keyed_entry_flag,
   input wire logic                controller_ready_flag,
   input wire logic                servo_ready_flag,
   input wire logic                cycle_running_flag,
   input wire logic                cycle_executing_flag,
   input wire logic                cycle_held_flag,
   input wire logic                all_axes_no_lag,
   input wire logic [NUM_AXES-1:0] pos_ctrl_en
);
   // **********
   // shared views
   // **********
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic [4:0] mode_v;   // all mode indicators
   assign mode_v = {keyed_entry_flag, reel_input_flag, stored_program_flag,
                    auto_initial_setup_flag, homing_mode_flag};
   // any cause that must drop servo ready
   sequence s_srv_fault;
      servo_alarm || estop_in || !power_good || cpu_fault;
   endsequence
   // **********
   // assertions
   // **********
   a_mode_onehot: assert property ($onehot0(mode_v))
      else $error("more than one mode flag");
   a_mode_lag: assert property ((mode_v != $past(mode_v)) |->
      $past(all_axes_no_lag)) else $error("mode switched under lag");
   a_lag_calc: assert property (all_axes_no_lag ==
      &(~axis_accel_busy | plc_axis)) else $error("no lag value wrong");
   a_ctrl_rise: assert property ($rose(controller_ready_flag) |->
      $past(power_good && !cpu_fault)) else $error("ready set under fault");
   a_ctrl_drop: assert property ((!power_good || cpu_fault ||
      (servo_alarm && !alarm_resettable)) |=> !controller_ready_flag)
      else $error("controller ready kept");
   a_srv_drop: assert property (s_srv_fault |=> !servo_ready_flag)
      else $error("servo ready kept");
   a_srv_keep: assert property ((servo_ready_flag && !servo_alarm &&
      !estop_in && power_good && !cpu_fault) |=> servo_ready_flag)
      else $error("servo ready lost");
   a_pos_gate: assert property (!servo_ready_flag |=> pos_ctrl_en == '0)
      else $error("position control on");
   a_cyc_codes: assert property (!(cycle_executing_flag &&
      cycle_held_flag) && (cycle_running_flag || !(cycle_executing_flag ||
      cycle_held_flag))) else $error("illegal cycle flags");
   a_cyc_reset: assert property ((estop_in || servo_alarm) |=>
      !(cycle_running_flag || cycle_executing_flag || cycle_held_flag))
      else $error("cycle flags kept");
   a_cyc_manual: assert property (!(stored_program_flag ||
      reel_input_flag || keyed_entry_flag) |=> !cycle_running_flag)
      else $error("running outside auto");
endmodule : ncs_status_chk

bind ncs_status ncs_status_chk i_ncs_status_chk (.*);

// ===== ncs_axis_model.sv
`timescale 1ns/100ps
module ncs_axis_model
   import ncs_pkg::*;
(
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   input  wire logic                lag_load,
   input  wire logic [7:0]          lag_len,
   output logic      [NUM_AXES-1:0] axis_accel_busy
);
   logic [7:0] lag_cnt;   // smoothing delay left on axis 0
   // **********
   // countdown of the smoothing delay
   // **********
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         lag_cnt <= 8'h00;
      else if (lag_load)
         lag_cnt <= lag_len;
      else if (lag_cnt != 8'h00)
         lag_cnt <= lag_cnt - 8'h01;
   end
   // only axis 0 moves, so the mode logic waits on one busy bit
   assign axis_accel_busy = {{(NUM_AXES-1){1'b0}}, (lag_cnt != 8'h00)};
endmodule : ncs_axis_model

// ===== ncs_status_tb.sv
`timescale 1ns/100ps
module ncs_status_tb
   import ncs_pkg::*;
;
   // **********
   // signals
   // **********
   logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, blk_end;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, axis_accel_busy, plc_axis, servo_off_cmd_n, pos_ctrl_en;
   logic power_good, cpu_fault, servo_diag_ok, servo_alarm, estop_in, err;
   logic alarm_resettable, lag_load, all_axes_no_lag;
   logic homing_mode_flag, auto_initial_setup_flag, stored_program_flag;
   logic reel_input_flag, keyed_entry_flag, controller_ready_flag;
   logic servo_ready_flag, cycle_running_flag, cycle_executing_flag;
   logic cycle_held_flag;
   logic [7:0] lag_len;
   int error_cnt, check_count, cyc_cnt;
   wire [2:0] cyc_f = {cycle_running_flag, cycle_executing_flag,
                       cycle_held_flag};   // run, exec, held
   wire [1:0] rdy_f = {controller_ready_flag, servo_ready_flag};
   wire [4:0] mode_f = {keyed_entry_flag, reel_input_flag,
                        stored_program_flag, auto_initial_setup_flag,
                        homing_mode_flag};
   ncs_status i_ncs_status (.*);
   ncs_axis_model i_ncs_axis_model (.clk_sys(clk_sys), .rst_n(rst_n),
      .lag_load(lag_load), .lag_len(lag_len),
      .axis_accel_busy(axis_accel_busy));
   // **********
   // helpers
   // **********
   task w(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : w
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer, held until pready is seen high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task test_done;
      if (error_cnt == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done
   // **********
   // scenarios
   // **********
   task t_regs;   // reset values, unmapped place
      apb(1'b0, OFS_CTRL, 32'h0); chk(rd, 32'h8);
      chk(cyc_f, 3'b000);
      chk(rdy_f, 2'b11);
      apb(1'b0, 8'h10, 32'h0); chk(err, 1'b1);
   endtask : t_regs
   task t_modes;   // each of the five flagged modes waits out the axis lag
      logic [4:0] prev;
      prev = 5'h00;
      for (int k = 1; k <= 5; k++)
      begin
         lag_len <= 8'h0a; lag_load <= 1'b1; w(1); lag_load <= 1'b0;
         apb(1'b1, OFS_CTRL, 32'h8 | 32'(k)); w(3);
         chk(mode_f, prev);
         w(8); prev = 5'h01 << (k - 1);
         chk(mode_f, prev);
      end
      plc_axis <= 4'h1; lag_load <= 1'b1; w(1); lag_load <= 1'b0; w(1);
      chk(all_axes_no_lag, 1'b1);
      plc_axis <= 4'h0; w(10);
   endtask : t_modes
   task t_cycle;   // keyed entry mode is active here
      apb(1'b1, OFS_CMD, 32'h1); w(3); chk(cyc_f, 3'b110);
      apb(1'b0, OFS_STAT, 32'h0); chk(rd, 32'h5f0);
      apb(1'b1, OFS_CTRL, 32'h05); w(3); chk(cyc_f, 3'b101);
      apb(1'b1, OFS_CMD, 32'h1); w(3); chk(cyc_f, 3'b101);
      apb(1'b1, OFS_CTRL, 32'h2d); apb(1'b1, OFS_CMD, 32'h1); w(3);
      chk(cyc_f, 3'b110);
      blk_end <= 1'b1; w(1); blk_end <= 1'b0; w(2);
      chk(cyc_f, 3'b100);
      apb(1'b1, OFS_CTRL, 32'h1d); w(3); chk(cyc_f, 3'b000);
      apb(1'b1, OFS_CTRL, 32'h0d); apb(1'b1, OFS_CMD, 32'h1); w(3);
      apb(1'b1, OFS_CTRL, 32'h09); w(3); chk(cyc_f, 3'b000);
      apb(1'b1, OFS_CTRL, 32'h0e); w(3); chk(mode_f, 5'h00);
   endtask : t_cycle
   task t_ready;   // fault and recovery of both ready flags
      estop_in <= 1'b1; w(2); chk(rdy_f, 2'b10);
      estop_in <= 1'b0; w(3); chk(rdy_f, 2'b11);
      servo_off_cmd_n <= 4'h0; w(3); chk(rdy_f, 2'b11);
      chk(pos_ctrl_en, 4'h0);
      servo_off_cmd_n <= 4'hf; w(3); chk(pos_ctrl_en, 4'hf);
      servo_alarm <= 1'b1; w(2); chk(rdy_f, 2'b10);
      servo_alarm <= 1'b0; w(3); chk(rdy_f, 2'b11);
      alarm_resettable <= 1'b0; servo_alarm <= 1'b1; w(2);
      chk(rdy_f, 2'b00);
      servo_alarm <= 1'b0; alarm_resettable <= 1'b1; w(3);
      chk(controller_ready_flag, 1'b0);
      power_good <= 1'b0; w(2); chk(rdy_f, 2'b00);
      power_good <= 1'b1; w(3); chk(controller_ready_flag, 1'b1);
      cpu_fault <= 1'b1; w(2); chk(rdy_f, 2'b00);
      cpu_fault <= 1'b0; w(2);
   endtask : t_ready
   // **********
   // clock, timeout, main sequence
   // **********
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // a hang counts as a mismatch
   always @(posedge clk_sys)
   begin
      cyc_cnt++;
      if (cyc_cnt == 3000)
      begin
         error_cnt++;
         test_done;
      end
   end
   initial
   begin
      rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; pstrb = 4'hf; blk_end = 1'b0;
      power_good = 1'b1; cpu_fault = 1'b0; servo_diag_ok = 1'b1;
      servo_alarm = 1'b0; alarm_resettable = 1'b1; estop_in = 1'b0;
      plc_axis = 4'h0; servo_off_cmd_n = 4'hf; lag_load = 1'b0;
      lag_len = 8'h00; error_cnt = 0; check_count = 0; cyc_cnt = 0;
      w(4); rst_n <= 1'b1; w(4);
      t_regs;
      t_modes;
      t_cycle;
      t_ready;
      test_done;
   end
endmodule : ncs_status_tb
